// >>> verilog/sfr_pkg.sv
/*
 Constants, cycle counts and state types shared by both ends of the
 flash reset sequencing link. Assumes the device end runs on the link
 clock (6 ns) and the host end on sys_clk (4 ns).
*/
// Functional notes
// [R1] Device runs power-on restart for full delay
// [R2] Host keeps select high, silent during power-up
// [R3] Restart pin ignored during power-on restart
// [R4] Pin low at power-up end holds restart
// [R5] Host waits restart-to-select after late release
// [R6] Host keeps pin high for recovery interval
// [R7] Pin fall restores registers within busy time
// [R8] Failed power-up makes pin start full process
// [R9] Long pulse aborts, tri-states, ignores commands
// [R10] Host raises select when restarting mid-frame
// [R11] Pulse plus select gap covers busy time
// [R12] Select high gap after read, program, erase
// [R13] Serial clock limited per command class
// [R14] Power-up ends in standby, latch cleared
package sfr_pkg;

   // ---------------------------------------------------------------
   // Clock periods and printed times
   // ---------------------------------------------------------------
   localparam int SYS_PERIOD_PS    = 4000;
   localparam int LINK_PERIOD_PS   = 6000;
   localparam int POWERUP_DELAY_US = 300;
   localparam int RESTART_BUSY_US  = 35;
   localparam int RESTART_PULSE_NS = 200;
   localparam int TO_SELECT_NS     = 50;
   localparam int RECOVERY_NS      = 50;
   localparam int CS_HIGH_READ_NS  = 10;
   localparam int CS_HIGH_PE_NS    = 50;
   localparam int SCK_READ_MHZ     = 50;
   localparam int SCK_SINGLE_MHZ   = 133;
   localparam int SCK_MULTI_MHZ    = 104;
   localparam int SCK_QPP_MHZ      = 80;

   function automatic int cdiv(input int a, input int b);
      return (a + b - 1) / b;
   endfunction

   // ---------------------------------------------------------------
   // Device end, link clock cycles
   // ---------------------------------------------------------------
   localparam int DEV_CNT_W       = 16;
   localparam int DEV_POWERUP_CYC = POWERUP_DELAY_US * 1000000 / LINK_PERIOD_PS;
   localparam int DEV_BUSY_CYC    = RESTART_BUSY_US * 1000000 / LINK_PERIOD_PS;
   localparam int DEV_PULSE_CYC   = cdiv(RESTART_PULSE_NS * 1000, LINK_PERIOD_PS);

   // ---------------------------------------------------------------
   // Host end, sys_clk cycles
   // ---------------------------------------------------------------
   localparam int HOST_CNT_W       = 17;
   localparam int HOST_POWERUP_CYC = cdiv(POWERUP_DELAY_US * 1000000, SYS_PERIOD_PS);
   localparam int HOST_BUSY_CYC    = cdiv(RESTART_BUSY_US * 1000000, SYS_PERIOD_PS);
   localparam int HOST_PULSE_CYC   = cdiv(RESTART_PULSE_NS * 1000, SYS_PERIOD_PS);
   localparam int HOST_TOSEL_CYC   = cdiv(TO_SELECT_NS * 1000, SYS_PERIOD_PS);
   localparam int HOST_RECOV_CYC   = cdiv(RECOVERY_NS * 1000, SYS_PERIOD_PS);
   localparam int HOST_GAP_CYC     =
      ((HOST_BUSY_CYC - HOST_PULSE_CYC) > HOST_TOSEL_CYC ?
       (HOST_BUSY_CYC - HOST_PULSE_CYC) : HOST_TOSEL_CYC) + HOST_RECOV_CYC;
   localparam int CS_READ_CYC      = cdiv(CS_HIGH_READ_NS * 1000, SYS_PERIOD_PS);
   localparam int CS_PE_CYC        = cdiv(CS_HIGH_PE_NS * 1000, SYS_PERIOD_PS);

   // Half periods of the serial clock, in sys_clk cycles
   localparam int HALF_READ   = (cdiv(1000000 / SCK_READ_MHZ, SYS_PERIOD_PS) + 1) / 2;
   localparam int HALF_SINGLE = (cdiv(1000000 / SCK_SINGLE_MHZ, SYS_PERIOD_PS) + 1) / 2;
   localparam int HALF_MULTI  = (cdiv(1000000 / SCK_MULTI_MHZ, SYS_PERIOD_PS) + 1) / 2;
   localparam int HALF_QPP    = (cdiv(1000000 / SCK_QPP_MHZ, SYS_PERIOD_PS) + 1) / 2;

   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      CLS_READ   = 2'h0,
      CLS_SINGLE = 2'h1,
      CLS_MULTI  = 2'h2,
      CLS_QPP    = 2'h3
   } sfr_cls_t;

   typedef enum logic [1:0] {
      D_POR     = 2'h0,
      D_STANDBY = 2'h1,
      D_BUSY    = 2'h3,
      D_PORHOLD = 2'h2
   } sfr_dev_state_t;

   typedef enum logic [2:0] {
      H_PWRUP  = 3'h0,
      H_IDLE   = 3'h1,
      H_FRAME  = 3'h3,
      H_CSGAP  = 3'h2,
      H_RSTLOW = 3'h6,
      H_RSTGAP = 3'h7
   } sfr_host_state_t;

endpackage

// >>> verilog/sfr_link_if.sv
/*
 Pin bundle between the host controller and the flash device end.
 Assumes the device drives the data-out pin only with its enable high;
 an undriven data-out line reads low.
*/
`timescale 1ns/10ps
interface sfr_link_if;
   logic csN;
   logic sck;
   logic rstN;
   logic mosi;
   logic misoOut;
   logic misoOe;
   logic misoLine;

   assign misoLine = misoOe ? misoOut : 1'b0;

   modport host (
      output csN,
      output sck,
      output rstN,
      output mosi,
      input  misoLine
   );

   modport dev (
      input  csN,
      input  sck,
      input  rstN,
      input  mosi,
      output misoOut,
      output misoOe
   );
endinterface

// >>> verilog/sfr_device.sv
/*
 Device end: power-on and warm restart sequencing, select gating and
 output tri-state control. Assumes linkClk runs free and nrst is
 synchronous to it; all link pins and vccOk are asynchronous.
*/
`timescale 1ns/10ps
module sfr_device
   import sfr_pkg::*;
#(
   parameter int POWERUP_CYC = DEV_POWERUP_CYC,
   parameter int BUSY_CYC    = DEV_BUSY_CYC,
   parameter int PULSE_CYC   = DEV_PULSE_CYC
) (
   input  wire logic linkClk,
   input  wire logic nrst,
   sfr_link_if.dev   flash,
   input  wire logic vccOk,
   input  wire logic porOk,
   input  wire logic txBit,
   input  wire logic txDrive,
   output logic      inStandby,
   output logic      cmdIgnore,
   output logic      selected,
   output logic      sckRise,
   output logic      mosiBit,
   output logic      regRestore,
   output logic      abortOp,
   output logic      welClear,
   output logic      ifStandby
);

   // ---------------------------------------------------------------
   // Parameter checks
   // ---------------------------------------------------------------
   if (POWERUP_CYC < 1 || POWERUP_CYC >= (1 << DEV_CNT_W)) begin : g_bad_pu
      $error("POWERUP_CYC out of range");
   end
   if (BUSY_CYC < 1 || BUSY_CYC >= (1 << DEV_CNT_W)) begin : g_bad_busy
      $error("BUSY_CYC out of range");
   end
   if (PULSE_CYC < 2 || PULSE_CYC > 63) begin : g_bad_pulse
      $error("PULSE_CYC out of range");
   end

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   typedef struct packed {
      sfr_dev_state_t       st;
      logic [DEV_CNT_W-1:0] cnt;
      logic [5:0]           low;
      logic                 porBad;
      logic                 vccS1;
      logic                 vccS2;
      logic                 csS1;
      logic                 csS2;
      logic                 sckS1;
      logic                 sckS2;
      logic                 sckD;
      logic                 rstS1;
      logic                 rstS2;
      logic                 rstD;
      logic                 mosiS1;
      logic                 mosiS2;
      logic                 misoOut;
      logic                 misoOe;
      logic                 inStandby;
      logic                 cmdIgnore;
      logic                 selected;
      logic                 sckRise;
      logic                 mosiBit;
      logic                 regRestore;
      logic                 abortOp;
      logic                 welClear;
      logic                 ifStandby;
   } sfr_dev_r_t;

   sfr_dev_r_t r_reg;
   sfr_dev_r_t r_next;

   always_comb begin
      r_next            = r_reg;
      r_next.vccS1      = vccOk;
      r_next.vccS2      = r_reg.vccS1;
      r_next.csS1       = flash.csN;
      r_next.csS2       = r_reg.csS1;
      r_next.sckS1      = flash.sck;
      r_next.sckS2      = r_reg.sckS1;
      r_next.sckD       = r_reg.sckS2;
      r_next.rstS1      = flash.rstN;
      r_next.rstS2      = r_reg.rstS1;
      r_next.rstD       = r_reg.rstS2;
      r_next.mosiS1     = flash.mosi;
      r_next.mosiS2     = r_reg.mosiS1;
      r_next.regRestore = 1'b0;
      r_next.abortOp    = 1'b0;
      r_next.welClear   = 1'b0;
      r_next.ifStandby  = 1'b0;
      if (!r_reg.vccS2) begin
         // Supply below threshold: restart from the top
         r_next.st  = D_POR; // see [R1]
         r_next.cnt = '0;
      end else begin
         case (r_reg.st)
            D_POR: begin
               // Restart pin looked at only when the delay ends
               if (r_reg.cnt == DEV_CNT_W'(POWERUP_CYC - 1)) begin // see [R1] [R3]
                  r_next.cnt      = '0;
                  r_next.porBad   = ~porOk;
                  r_next.welClear = 1'b1; // see [R14]
                  r_next.st       = r_reg.rstS2 ? D_STANDBY : D_PORHOLD; // see [R4]
               end else begin
                  r_next.cnt = r_reg.cnt + 1'b1;
               end
            end
            D_PORHOLD: begin
               if (r_reg.rstS2) begin
                  r_next.st = D_STANDBY; // see [R4] [R14]
               end
            end
            D_STANDBY: begin
               if (r_reg.rstD && !r_reg.rstS2) begin
                  r_next.cnt = '0;
                  r_next.low = '0;
                  if (r_reg.porBad) begin
                     r_next.st = D_POR; // see [R8]
                  end else begin
                     r_next.st         = D_BUSY;
                     r_next.regRestore = 1'b1; // see [R7]
                  end
               end
            end
            D_BUSY: begin
               if (r_reg.cnt != DEV_CNT_W'(BUSY_CYC - 1)) begin
                  r_next.cnt = r_reg.cnt + 1'b1;
               end
               if (!r_reg.rstS2 && r_reg.low != 6'(PULSE_CYC - 1)) begin
                  r_next.low = r_reg.low + 1'b1;
               end
               // Pulse long enough: abort whatever is running
               if (!r_reg.rstS2 && r_reg.low == 6'(PULSE_CYC - 2)) begin
                  r_next.abortOp = 1'b1; // see [R9]
               end
               if (r_reg.cnt == DEV_CNT_W'(BUSY_CYC - 1) && r_reg.rstS2) begin
                  r_next.st        = D_STANDBY; // see [R7] [R9]
                  r_next.cnt       = '0;
                  r_next.ifStandby = 1'b1;
               end
            end
            default: begin
               r_next.st = D_POR;
            end
         endcase
      end
      // Commands only reach the core in standby; outputs float otherwise
      r_next.inStandby = (r_next.st == D_STANDBY);
      r_next.cmdIgnore = ~r_next.inStandby; // see [R9]
      r_next.selected  = r_next.inStandby & ~r_reg.csS2;
      r_next.sckRise   = r_next.selected & r_reg.sckS2 & ~r_reg.sckD;
      r_next.mosiBit   = r_reg.mosiS2;
      r_next.misoOe    = r_next.selected & txDrive; // see [R9]
      r_next.misoOut   = txBit;
   end

   always_ff @(posedge linkClk) begin
      if (!nrst) begin
         r_reg <= '0;
      end else begin
         r_reg <= r_next;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   assign flash.misoOut = r_reg.misoOut;
   assign flash.misoOe  = r_reg.misoOe;
   assign inStandby     = r_reg.inStandby;
   assign cmdIgnore     = r_reg.cmdIgnore;
   assign selected      = r_reg.selected;
   assign sckRise       = r_reg.sckRise;
   assign mosiBit       = r_reg.mosiBit;
   assign regRestore    = r_reg.regRestore;
   assign abortOp       = r_reg.abortOp;
   assign welClear      = r_reg.welClear;
   assign ifStandby     = r_reg.ifStandby;

endmodule // sfr_device

// >>> verilog/sfr_host.sv
/*
 Host end: drives select, serial clock and restart pin of the flash,
 paces power-up and restart waits and runs one shift frame per command.
 Assumes sys_clk at 250 MHz, nrst synchronous to it, user side on
 sys_clk; the data-out line from the device is asynchronous.
*/
`timescale 1ns/10ps
module sfr_host
   import sfr_pkg::*;
#(
   parameter int POWERUP_CYC = HOST_POWERUP_CYC,
   parameter int PULSE_CYC   = HOST_PULSE_CYC,
   parameter int GAP_CYC     = HOST_GAP_CYC
) (
   input  wire logic        sys_clk,
   input  wire logic        nrst,
   sfr_link_if.host         flash,
   input  wire logic        rstReq,
   input  wire logic        cmdValid,
   input  sfr_cls_t         cmdClass,
   input  wire logic        cmdProgErase,
   input  wire logic [5:0]  cmdLen,
   input  wire logic [31:0] cmdData,
   output logic             cmdReady,
   output logic             linkUp,
   output logic             rdValid,
   output logic [31:0]      rdData
);

   // ---------------------------------------------------------------
   // Parameter checks
   // ---------------------------------------------------------------
   if (POWERUP_CYC < 1 || POWERUP_CYC >= (1 << HOST_CNT_W)) begin : g_bad_pu
      $error("POWERUP_CYC out of range");
   end
   if (PULSE_CYC < 1 || PULSE_CYC >= (1 << HOST_CNT_W)) begin : g_bad_pulse
      $error("PULSE_CYC out of range");
   end
   if (GAP_CYC < 1 || GAP_CYC >= (1 << HOST_CNT_W)) begin : g_bad_gap
      $error("GAP_CYC out of range");
   end

   // ---------------------------------------------------------------
   // Serial clock half period per command class
   // ---------------------------------------------------------------
   function automatic logic [1:0] halfOf(input sfr_cls_t c);
      logic [1:0] h;
      h = 2'(HALF_SINGLE);
      case (c)
         CLS_READ:   h = 2'(HALF_READ);
         CLS_SINGLE: h = 2'(HALF_SINGLE);
         CLS_MULTI:  h = 2'(HALF_MULTI);
         CLS_QPP:    h = 2'(HALF_QPP);
         default:    h = 2'(HALF_READ);
      endcase
      return h;
   endfunction

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   typedef struct packed {
      sfr_host_state_t       st;
      logic [HOST_CNT_W-1:0] cnt;
      logic [1:0]            half;
      logic [1:0]            halfMax;
      logic [5:0]            bits;
      logic [5:0]            len;
      logic [31:0]           tx;
      logic [31:0]           rx;
      logic                  pe;
      logic                  early;
      logic                  misoS1;
      logic                  misoS2;
      logic                  csN;
      logic                  sck;
      logic                  rstN;
      logic                  mosi;
      logic                  ready;
      logic                  linkUp;
      logic                  rdValid;
      logic [31:0]           rdData;
   } sfr_host_r_t;

   sfr_host_r_t r_reg;
   sfr_host_r_t r_next;

   always_comb begin
      r_next         = r_reg;
      r_next.misoS1  = flash.misoLine;
      r_next.misoS2  = r_reg.misoS1;
      r_next.rdValid = 1'b0;
      case (r_reg.st)
         H_PWRUP: begin
            // Select stays high; a restart request only pulls the pin
            if (rstReq) begin
               r_next.early = 1'b1;
               r_next.rstN  = 1'b0;
            end
            if (r_reg.cnt == HOST_CNT_W'(POWERUP_CYC - 1)) begin // see [R2]
               r_next.cnt    = '0;
               r_next.linkUp = 1'b1;
               if (r_reg.early || rstReq) begin
                  r_next.st = H_RSTLOW; // see [R5]
               end else begin
                  r_next.st    = H_IDLE;
                  r_next.ready = 1'b1;
               end
            end else begin
               r_next.cnt = r_reg.cnt + 1'b1;
            end
         end
         H_IDLE: begin
            if (rstReq) begin
               r_next.st    = H_RSTLOW;
               r_next.rstN  = 1'b0;
               r_next.cnt   = '0;
               r_next.ready = 1'b0;
            end else if (cmdValid && cmdLen != 6'h00 && cmdLen <= 6'h20) begin
               r_next.st      = H_FRAME;
               r_next.ready   = 1'b0;
               r_next.csN     = 1'b0;
               r_next.tx      = cmdData;
               r_next.mosi    = cmdData[31];
               r_next.len     = cmdLen;
               r_next.pe      = cmdProgErase;
               r_next.halfMax = halfOf(cmdClass); // see [R13]
               r_next.half    = 2'h0;
               r_next.bits    = 6'h00;
               r_next.rx      = '0;
            end
         end
         H_FRAME: begin
            if (rstReq) begin
               // Drop the frame: select high while the pin goes low
               r_next.csN  = 1'b1; // see [R10]
               r_next.sck  = 1'b0;
               r_next.rstN = 1'b0;
               r_next.cnt  = '0;
               r_next.st   = H_RSTLOW;
            end else if (r_reg.half == r_reg.halfMax - 2'h1) begin // see [R13]
               r_next.half = 2'h0;
               if (!r_reg.sck) begin
                  r_next.sck  = 1'b1;
                  r_next.rx   = {r_reg.rx[30:0], r_reg.misoS2};
                  r_next.bits = r_reg.bits + 1'b1;
               end else if (r_reg.bits == r_reg.len) begin
                  r_next.sck     = 1'b0;
                  r_next.csN     = 1'b1;
                  r_next.cnt     = '0;
                  r_next.rdData  = r_reg.rx;
                  r_next.rdValid = 1'b1;
                  r_next.st      = H_CSGAP;
               end else begin
                  r_next.sck  = 1'b0;
                  r_next.tx   = {r_reg.tx[30:0], 1'b0};
                  r_next.mosi = r_reg.tx[30];
               end
            end else begin
               r_next.half = r_reg.half + 2'h1;
            end
         end
         H_CSGAP: begin
            if (rstReq) begin
               r_next.rstN = 1'b0;
               r_next.cnt  = '0;
               r_next.st   = H_RSTLOW;
            end else if ((r_reg.pe && r_reg.cnt == HOST_CNT_W'(CS_PE_CYC - 1)) ||
                         (!r_reg.pe && r_reg.cnt == HOST_CNT_W'(CS_READ_CYC - 1))) begin
               r_next.st    = H_IDLE; // see [R12]
               r_next.ready = 1'b1;
               r_next.cnt   = '0;
            end else begin
               r_next.cnt = r_reg.cnt + 1'b1;
            end
         end
         H_RSTLOW: begin
            r_next.rstN  = 1'b0;
            r_next.early = 1'b0;
            if (r_reg.cnt == HOST_CNT_W'(PULSE_CYC - 1)) begin
               r_next.rstN = 1'b1;
               r_next.cnt  = '0;
               r_next.st   = H_RSTGAP;
            end else begin
               r_next.cnt = r_reg.cnt + 1'b1;
            end
         end
         H_RSTGAP: begin
            // Pulse plus this wait covers busy time and recovery
            if (r_reg.cnt == HOST_CNT_W'(GAP_CYC - 1)) begin // see [R5] [R6] [R11]
               r_next.st    = H_IDLE;
               r_next.ready = 1'b1;
               r_next.cnt   = '0;
            end else begin
               r_next.cnt = r_reg.cnt + 1'b1;
            end
         end
         default: begin
            r_next.st = H_PWRUP;
         end
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         r_reg      <= '0;
         r_reg.csN  <= 1'b1;
         r_reg.rstN <= 1'b1;
      end else begin
         r_reg <= r_next;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   assign flash.csN  = r_reg.csN;
   assign flash.sck  = r_reg.sck;
   assign flash.rstN = r_reg.rstN;
   assign flash.mosi = r_reg.mosi;
   assign cmdReady   = r_reg.ready;
   assign linkUp     = r_reg.linkUp;
   assign rdValid    = r_reg.rdValid;
   assign rdData     = r_reg.rdData;

endmodule // sfr_host

// >>> tb/sfr_link_props.sv
/*
 Checker for the select, clock, restart and data-out pins of the link.
 Assumes the host drives its pins from sys_clk and the device from linkClk.
*/
`timescale 1ns/10ps
module sfr_link_props #(
   parameter int PWRUP = 320,
   parameter int PULSE = 10,
   parameter int BUSY  = 150,
   parameter int TOSEL = 13,
   parameter int RECOV = 13
) (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic linkClk,
   input wire logic linkNrst,
   input wire logic csN,
   input wire logic sck,
   input wire logic rstN,
   input wire logic misoOe
);
   // ----------------------------------------------------------------
   // Saturating cycle counters on sys_clk
   // ----------------------------------------------------------------
   logic [15:0] loCnt, hiCnt, upCnt, riseCnt, fallCnt;
   function automatic logic [15:0] inc(input logic [15:0] v);
      return (v == 16'hffff) ? v : v + 16'h1;
   endfunction
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         loCnt <= 16'h0;
         hiCnt <= 16'hffff;
         upCnt <= 16'h0;
         riseCnt <= 16'hffff;
         fallCnt <= 16'hffff;
      end else begin
         loCnt <= rstN ? 16'h0 : inc(loCnt);
         hiCnt <= rstN ? inc(hiCnt) : 16'h0;
         upCnt <= inc(upCnt);
         riseCnt <= $rose(rstN) ? 16'h0 : inc(riseCnt);
         fallCnt <= $fell(rstN) ? 16'h0 : inc(fallCnt);
      end
   end
   chk_pwrup_quiet: assert property (@(posedge sys_clk) disable iff (!nrst)
      !csN |-> upCnt >= PWRUP) else $error("select low during power-up wait");
   chk_pulse_width: assert property (@(posedge sys_clk) disable iff (!nrst)
      $rose(rstN) |-> loCnt >= PULSE) else $error("restart pulse too short");
   chk_restart_recov: assert property (@(posedge sys_clk) disable iff (!nrst)
      $fell(rstN) |-> hiCnt >= RECOV) else $error("restart pin high time too short");
   chk_select_hold: assert property (@(posedge sys_clk) disable iff (!nrst)
      $fell(csN) |-> riseCnt >= TOSEL) else $error("select too soon after restart");
   chk_busy_cover: assert property (@(posedge sys_clk) disable iff (!nrst)
      $fell(csN) |-> fallCnt >= BUSY) else $error("select inside restart busy time");
   chk_restart_desel: assert property (@(posedge sys_clk) disable iff (!nrst)
      !rstN |-> csN) else $error("select low while restart pin low");
   chk_cs_gap: assert property (@(posedge sys_clk) disable iff (!nrst)
      $rose(csN) |-> csN [*3]) else $error("select high gap too short");
   chk_sck_frame: assert property (@(posedge sys_clk) disable iff (!nrst)
      $rose(sck) |-> !csN && !$past(csN)) else $error("serial clock outside frame");
   chk_tri_state: assert property (@(posedge linkClk) disable iff (!linkNrst)
      !rstN [*6] |-> !misoOe) else $error("data out driven during restart");
   chk_idle_drive: assert property (@(posedge linkClk) disable iff (!linkNrst)
      csN [*6] |-> !misoOe) else $error("data out driven while deselected");
   cov_restart: cover property (@(posedge sys_clk) disable iff (!nrst) $fell(rstN));
   cov_frame: cover property (@(posedge sys_clk) disable iff (!nrst) $fell(csN));
   cov_drive: cover property (@(posedge linkClk) disable iff (!linkNrst) $rose(misoOe));
endmodule // sfr_link_props

// >>> tb/test_serial_flash_reset_sequencing.sv
/*
 Bench joining the host and device ends over one link.
 Assumes both design ends and the link interface are compiled first.
*/
`timescale 1ns/10ps
module test_serial_flash_reset_sequencing;
   import sfr_pkg::*;
   // ----------------------------------------------------------------
   // Stimulus, monitors and scenarios
   // ----------------------------------------------------------------
   localparam int HPU = 320, DPU = 200;
   logic sys_clk = 0, linkClk = 0, nrst = 0, linkNrst = 0, vccOk = 0, porOk = 1;
   logic txBit = 0, txDrive = 1, rstReq = 0, cmdValid = 0, cmdPE = 0;
   sfr_cls_t cmdClass = CLS_READ;
   logic [5:0] cmdLen = 6'h20;
   logic [31:0] cmdData = 32'h0, rnd = 32'h43, rdData;
   logic cmdReady, linkUp, rdValid, inStandby, cmdIgnore, welClear;
   logic regRestore, abortOp, ifStandby;
   int fail_count = 0, checks = 0, linkCyc = 0, welN = 0, rrN = 0, abN = 0, ifsN = 0, welMark;
   logic [23:0] expQ[$];
   sfr_link_if flash();
   sfr_host #(.POWERUP_CYC(HPU), .GAP_CYC(160)) u_sfr_host (
      .sys_clk(sys_clk), .nrst(nrst), .flash(flash.host), .rstReq(rstReq),
      .cmdValid(cmdValid), .cmdClass(cmdClass), .cmdProgErase(cmdPE), .cmdLen(cmdLen),
      .cmdData(cmdData), .cmdReady(cmdReady), .linkUp(linkUp), .rdValid(rdValid),
      .rdData(rdData));
   sfr_device #(.POWERUP_CYC(DPU), .BUSY_CYC(100), .PULSE_CYC(4)) u_sfr_device (
      .linkClk(linkClk), .nrst(linkNrst), .flash(flash.dev), .vccOk(vccOk),
      .porOk(porOk), .txBit(txBit), .txDrive(txDrive), .inStandby(inStandby),
      .cmdIgnore(cmdIgnore), .selected(), .sckRise(), .mosiBit(), .regRestore(regRestore),
      .abortOp(abortOp), .welClear(welClear), .ifStandby(ifStandby));
   sfr_link_props #(.PWRUP(HPU), .PULSE(HOST_PULSE_CYC), .BUSY(150), .TOSEL(HOST_TOSEL_CYC),
      .RECOV(HOST_RECOV_CYC)) u_sfr_link_props (
      .sys_clk(sys_clk), .nrst(nrst), .linkClk(linkClk), .linkNrst(linkNrst),
      .csN(flash.csN), .sck(flash.sck), .rstN(flash.rstN), .misoOe(flash.misoOe));
   initial forever #2 sys_clk = ~sys_clk;
   initial begin
      #1.3;
      forever #3 linkClk = ~linkClk;
   end
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   always @(posedge linkClk) begin
      linkCyc <= linkNrst ? linkCyc + 1 : 0;
      if (welClear === 1'b1) begin
         welN <= welN + 1;
         check("powerup", 1, linkCyc >= DPU);
         check("por_state", flash.rstN, inStandby);
      end
      if (regRestore === 1'b1) rrN <= rrN + 1;
      if (ifStandby === 1'b1) ifsN <= ifsN + 1;
      if (abortOp === 1'b1) begin
         abN <= abN + 1;
         check("ignore", 1, cmdIgnore);
      end
   end
   always @(posedge sys_clk)
      if (rdValid === 1'b1) begin
         if (expQ.size() == 0) check("rd_extra", 0, 1);
         else check("rdData", expQ.pop_front(), rdData[23:0]);
      end
   task automatic wait_ready();
      int n;
      n = 0;
      do begin
         @(negedge sys_clk);
         n++;
      end while (cmdReady !== 1'b1 && n < 4000);
      check("cmdReady", 1, cmdReady);
   endtask
   task automatic restart();
      @(posedge sys_clk);
      rstReq <= 1;
      @(posedge sys_clk);
      rstReq <= 0;
   endtask
   task automatic send(input logic [1:0] cls, input logic pe, input logic push);
      wait_ready();
      rnd = lfsr(rnd);
      @(posedge sys_clk);
      cmdValid <= 1;
      cmdClass <= sfr_cls_t'(cls);
      cmdPE <= pe;
      cmdData <= rnd;
      cmdLen <= 6'h1b + {4'h0, rnd[3:2]};
      txBit <= rnd[0];
      txDrive <= rnd[1];
      if (push) expQ.push_back({24{rnd[0] & rnd[1]}});
      @(posedge sys_clk);
      cmdValid <= 0;
   endtask
   task automatic do_reset(input logic por, input logic early);
      @(posedge sys_clk);
      nrst <= 0;
      linkNrst <= 0;
      vccOk <= 0;
      porOk <= por;
      repeat (4) @(posedge sys_clk);
      nrst <= 1;
      vccOk <= 1;
      @(posedge linkClk);
      linkNrst <= 1;
      if (early) restart();
   endtask
   initial begin
      do_reset(1, 0);
      wait_ready();
      check("standby", 1, inStandby);
      check("linkUp", 1, linkUp);
      for (int i = 0; i < 8; i++) send(i[1:0], i[2], 1);
      // Restart in mid-frame, no read answer expected
      send(2'h0, 0, 0);
      repeat (6) @(posedge sys_clk);
      restart();
      wait_ready();
      check("restore", 1, rrN);
      check("abort", 1, abN);
      check("ifstby", 1, ifsN);
      send(2'h1, 1, 1);
      wait_ready();
      do_reset(1, 1);
      wait_ready();
      check("no_restore", 1, rrN);
      send(2'h2, 0, 1);
      wait_ready();
      check("queue", 0, expQ.size());
      do_reset(0, 0);
      wait_ready();
      welMark = welN;
      restart();
      repeat (500) @(posedge sys_clk);
      check("por_rerun", welMark + 1, welN);
      check("no_warm", 1, ifsN);
      finish_test();
   end
   initial begin
      #100000;
      fail_count++;
      finish_test();
   end
endmodule // test_serial_flash_reset_sequencing
